/* design/dac_cal_defines.svh */
// constants for the converter code calibration path
`ifndef DAC_CAL_DEFINES_SVH
`define DAC_CAL_DEFINES_SVH
`define REG_W 16
`define RES_FULL 16
`define RES_NARROW 14
`define JUST_SHIFT_NARROW 2
`define GAIN_UNITY 16'h8000
`define CODE_RST 16'h0000
`define GAIN_RST 16'h8000
`define OFFSET_RST 16'h0000
`define SYNC_STAGES 2
`define CAL_ACC_W 36
`define ZERO_CODE 16'h0000
`define FLAG_RST 1'h0
`endif

/* design/dac_cal_pkg.sv */
// types for the converter code calibration path
package dac_cal_pkg;
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] gain;
    logic [15:0] offset;
  } cal_regs_t;
  typedef struct packed {
    logic span_sel;
    logic safe_span_sel;
    logic safe_state_request;
    logic alarm_to_safe;
  } span_ctrl_t;
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_SAFE = 2'b01,
    ST_ALARM = 2'b11
  } out_state_t;
endpackage

/* design/dac_code_calibration_path.sv */
// gain and offset calibration of the converter code, span and safe-state selection
`timescale 1ns/10ps
`include "dac_cal_defines.svh"

// Notes on behaviour
// - converter code is output code times gain plus signed offset
// - converter code is unsigned, zero to two to resolution minus one
// - gain equals one half plus gain code over two to resolution
// - offset is two's complement across the resolution
// - top offset bit weighs minus two to resolution minus one
// - gain is left justified; narrow variant drops two low bits
// - output code is left justified; narrow variant drops two low bits
// - offset is left justified; narrow variant drops two low bits
// - gain product is truncated, never rounded
// - new gain or offset act only at next output code write
// - outside safe state span bit 0 full, 1 narrow
// - in safe state span comes from the safe-state span bit
// - supply fault raises alarm; output follows the fault response setting
// - entering safe state applies the stored safe-state code at once
// - written output code is synchronised with a short fixed latency
module dac_code_calibration_path #(
  parameter int RES = `RES_FULL
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register writes
  input wire logic code_wr,
  input wire logic [15:0] code_wdata,
  input wire logic gain_wr,
  input wire logic [15:0] gain_wdata,
  input wire logic offset_wr,
  input wire logic [15:0] offset_wdata,
  input wire logic [15:0] safe_state_code_register,
  // span and safe-state controls
  input wire dac_cal_pkg::span_ctrl_t ctrl,
  // supply monitor levels
  input wire logic main_supply_ok,
  input wire logic core_supply_ok,
  // register readback
  output logic [15:0] code_rd,
  output logic [15:0] gain_rd,
  output logic [15:0] offset_rd,
  // converter side
  output logic [15:0] converter_code,
  output logic narrow_span,
  output logic in_safe_state,
  output logic supply_alarm
);
  localparam int DROP = `REG_W - RES;
  localparam int ACC_W = `CAL_ACC_W;

  // register file
  dac_cal_pkg::cal_regs_t regs_ff, nxt_regs;
  // write strobe delay line and calibrated result
  logic [`SYNC_STAGES-1:0] wr_pipe_ff, nxt_wr_pipe;
  logic [ACC_W-1:0] cal_ff, nxt_cal;
  // output state
  dac_cal_pkg::out_state_t st_ff, nxt_st;
  logic [15:0] conv_ff, nxt_conv;
  logic narrow_ff, nxt_narrow;
  logic safe_ff, nxt_safe;
  // supply monitor
  logic alarm_ff, nxt_alarm;

  // calibration math, signed accumulator
  logic [15:0] d_j, g_j, o_j;
  logic signed [ACC_W-1:0] prod, half, offs, sum;
  logic signed [ACC_W-1:0] cal_s;
  logic [15:0] max_code;
  logic [15:0] sat_code;
  logic supplies_ok;
  logic alarm_hold;

  // keep the active bits of a left-justified field, right aligned
  function automatic logic [15:0] just(input logic [15:0] v);
    just = v >> DROP;
  endfunction

  // safe and alarm states both present the stored safe code
  function automatic logic holds_safe(input dac_cal_pkg::out_state_t s);
    holds_safe = (s != dac_cal_pkg::ST_NORMAL);
  endfunction

  // register writes
  always_comb begin
    nxt_regs = regs_ff;
    if (code_wr) begin
      nxt_regs.code = code_wdata;
    end
    if (gain_wr) begin
      nxt_regs.gain = gain_wdata;
    end
    if (offset_wr) begin
      nxt_regs.offset = offset_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regs_ff <= {`CODE_RST, `GAIN_RST, `OFFSET_RST};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // code write strobe delayed through the synchroniser
  assign nxt_wr_pipe[0] = code_wr;
  genvar gi;
  generate
    for (gi = 1; gi < `SYNC_STAGES; gi++) begin : g_wr_pipe
      assign nxt_wr_pipe[gi] = wr_pipe_ff[gi-1];
    end
  endgenerate

  always_comb begin
    d_j = just(regs_ff.code);
    g_j = just(regs_ff.gain);
    o_j = just(regs_ff.offset);
    // data*(1/2 + g/2^N) = data*(2^(N-1)+g) >> N, truncated
    half = signed'(ACC_W'(1) <<< (RES - 1));
    prod = signed'(ACC_W'(d_j)) * (half + signed'(ACC_W'(g_j)));
    prod = prod >>> RES;
    // sign bit at position RES-1 weighs negative
    offs = signed'(ACC_W'(o_j));
    if (o_j[RES-1]) begin
      offs = offs - (half <<< 1);
    end
    sum = prod + offs;
    // gain and offset sampled only with a new code write
    nxt_cal = cal_ff;
    if (wr_pipe_ff[0]) begin
      nxt_cal = sum;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pipe_ff <= '0;
      cal_ff <= '0;
    end else begin
      wr_pipe_ff <= nxt_wr_pipe;
      cal_ff <= nxt_cal;
    end
  end

  // clamp to the converter code range
  always_comb begin
    max_code = 16'((32'h1 << RES) - 32'h1);
    cal_s = signed'(cal_ff);
    if (cal_s < 0) begin
      sat_code = `ZERO_CODE;
    end else if (cal_s > signed'(ACC_W'(max_code))) begin
      sat_code = max_code;
    end else begin
      sat_code = cal_ff[15:0];
    end
  end

  // supply monitor
  always_comb begin
    supplies_ok = main_supply_ok && core_supply_ok;
    nxt_alarm = !supplies_ok;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_ff <= `FLAG_RST;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

  // output state: normal, requested safe, alarm-held safe
  always_comb begin
    alarm_hold = nxt_alarm && ctrl.alarm_to_safe;
    nxt_st = st_ff;
    case (st_ff)
      dac_cal_pkg::ST_NORMAL: begin
        if (alarm_hold) begin
          nxt_st = dac_cal_pkg::ST_ALARM;
        end else if (ctrl.safe_state_request) begin
          nxt_st = dac_cal_pkg::ST_SAFE;
        end
      end
      dac_cal_pkg::ST_SAFE: begin
        if (alarm_hold) begin
          nxt_st = dac_cal_pkg::ST_ALARM;
        end else if (!ctrl.safe_state_request) begin
          nxt_st = dac_cal_pkg::ST_NORMAL;
        end
      end
      dac_cal_pkg::ST_ALARM: begin
        if (!alarm_hold && ctrl.safe_state_request) begin
          nxt_st = dac_cal_pkg::ST_SAFE;
        end else if (!alarm_hold) begin
          nxt_st = dac_cal_pkg::ST_NORMAL;
        end
      end
      default: begin
        nxt_st = dac_cal_pkg::ST_NORMAL;
      end
    endcase
    nxt_safe = holds_safe(nxt_st);
    if (nxt_safe) begin
      nxt_conv = just(safe_state_code_register);
      nxt_narrow = ctrl.safe_span_sel;
    end else begin
      nxt_conv = wr_pipe_ff[`SYNC_STAGES-1] ? sat_code : conv_ff;
      nxt_narrow = ctrl.span_sel;
    end
    // leaving the safe state restores the last calibrated result
    if (holds_safe(st_ff) && !nxt_safe) begin
      nxt_conv = sat_code;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= dac_cal_pkg::ST_NORMAL;
      conv_ff <= `ZERO_CODE;
      narrow_ff <= `FLAG_RST;
      safe_ff <= `FLAG_RST;
    end else begin
      st_ff <= nxt_st;
      conv_ff <= nxt_conv;
      narrow_ff <= nxt_narrow;
      safe_ff <= nxt_safe;
    end
  end

  assign code_rd = regs_ff.code;
  assign gain_rd = regs_ff.gain;
  assign offset_rd = regs_ff.offset;
  assign converter_code = conv_ff;
  assign narrow_span = narrow_ff;
  assign in_safe_state = safe_ff;
  assign supply_alarm = alarm_ff;
endmodule

/* verification/dac_cal_asserts.sv */
// assertions on the calibration path ports
`timescale 1ns/10ps
module dac_cal_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register writes
  input wire logic code_wr,
  input wire logic gain_wr,
  input wire logic [15:0] gain_wdata,
  input wire logic [15:0] safe_state_code_register,
  // controls and supplies
  input wire dac_cal_pkg::span_ctrl_t ctrl,
  input wire logic main_supply_ok,
  input wire logic core_supply_ok,
  // watched outputs
  input wire logic [15:0] gain_rd,
  input wire logic [15:0] converter_code,
  input wire logic narrow_span,
  input wire logic in_safe_state,
  input wire logic supply_alarm
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  alarm_on_a: assert property (!(main_supply_ok && core_supply_ok) |=> supply_alarm)
    else $error("alarm missing");
  alarm_off_a: assert property (main_supply_ok && core_supply_ok |=> !supply_alarm)
    else $error("alarm stuck");
  alarm_safe_a: assert property (ctrl.alarm_to_safe &&
    !(main_supply_ok && core_supply_ok) |=> in_safe_state) else $error("no alarm safe state");
  safe_entry_a: assert property (ctrl.safe_state_request |=> in_safe_state)
    else $error("no safe state");
  safe_code_a: assert property (ctrl.safe_state_request |=>
    converter_code == $past(safe_state_code_register)) else $error("bad safe code");
  span_norm_a: assert property (!in_safe_state |->
    narrow_span == $past(ctrl.span_sel)) else $error("bad span");
  span_safe_a: assert property (in_safe_state |->
    narrow_span == $past(ctrl.safe_span_sel)) else $error("bad safe span");
  hold_cal_a: assert property ((!code_wr && !in_safe_state)[*4] |=>
    $stable(converter_code) || in_safe_state) else $error("code moved");
  gain_rb_a: assert property (gain_wr |=> gain_rd == $past(gain_wdata))
    else $error("gain readback");
endmodule
bind dac_code_calibration_path dac_cal_checker i_dac_cal_checker (.clk, .nrst, .code_wr,
  .gain_wr, .main_supply_ok, .core_supply_ok, .in_safe_state, .narrow_span, .supply_alarm,
  .gain_wdata, .gain_rd, .converter_code, .safe_state_code_register, .ctrl);

/* verification/loop_current_model.sv */
// loop current converter fed by the code
`timescale 1ns/10ps
module loop_current_model (
  // code and span from the calibration path
  input wire logic [15:0] converter_code,
  input wire logic narrow_span,
  // loop current in microamps
  output int loop_ua
);
  // narrow 4 to 20 mA, full 3 to 25 mA
  assign loop_ua = narrow_span ? 4000 + converter_code * 16000 / 65536
    : 3000 + converter_code * 22000 / 65536;
endmodule

/* verification/dac_code_calibration_path_test.sv */
// bench for the calibration path
`timescale 1ns/10ps
module dac_code_calibration_path_test;
  logic clk = 0, nrst = 0, code_wr = 0, gain_wr = 0, offset_wr = 0, narrow_span;
  logic main_supply_ok = 1, core_supply_ok = 1, in_safe_state, supply_alarm;
  logic [15:0] code_wdata = 0, gain_wdata = 0, offset_wdata = 0, code_rd, gain_rd, offset_rd;
  logic [15:0] safe_state_code_register = 16'h1234, converter_code, last, q[$];
  logic [3:0] sh = 0;
  dac_cal_pkg::span_ctrl_t ctrl = '0;
  int err_count = 0, checked = 0, cyc = 0, loop_ua;
  always #50 clk = ~clk;
  dac_code_calibration_path i_dac_code_calibration_path (.clk, .nrst, .code_wr, .code_wdata,
    .gain_wr, .gain_wdata, .offset_wr, .offset_wdata, .safe_state_code_register, .ctrl,
    .main_supply_ok, .core_supply_ok, .code_rd, .gain_rd, .offset_rd, .converter_code,
    .narrow_span, .in_safe_state, .supply_alarm);
  loop_current_model i_loop_current_model (.converter_code, .narrow_span, .loop_ua);
  task summarize;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  function logic [15:0] calc(logic [15:0] d, g, o);
    longint r;
    r = ((longint'(d) * (32768 + int'(g))) >>> 16) + $signed(o);
    calc = r < 0 ? 16'h0000 : r > 65535 ? 16'hffff : r[15:0];
  endfunction
  task cal(logic [15:0] g, o, d);
    @(negedge clk);
    {gain_wr, offset_wr, gain_wdata, offset_wdata} = {2'h3, g, o};
    @(negedge clk);
    {gain_wr, offset_wr, code_wr, code_wdata} = {3'h1, d};
    last = calc(d, g, o);
    q.push_back(last);
    @(negedge clk);
    code_wr = 0;
  endtask
  always @(posedge clk) sh <= {sh[2:0], code_wr};
  always @(negedge clk) begin
    if (sh[2]) chk("converter_code", q.pop_front(), converter_code);
    if (++cyc > 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(41));
    repeat (10) @(negedge clk);
    nrst = 1;
    chk("gain_rd", 16'h8000, gain_rd);
    chk("code_offset", 32'h0, {code_rd, offset_rd});
    cal(16'h8000, 16'h0000, 16'h1234);
    cal(16'h0000, 16'hfffe, 16'hffff);
    cal(16'hffff, 16'h7fff, 16'hffff);
    cal(16'h8000, 16'h8000, 16'h0010);
    repeat (9) cal(16'($urandom), 16'($urandom), 16'($urandom));
    @(negedge clk) {gain_wr, gain_wdata} = {1'h1, 16'h0000};
    @(negedge clk) gain_wr = 0;
    repeat (4) @(negedge clk);
    chk("held_code", last, converter_code);
    ctrl = 4'h6;
    repeat (2) @(negedge clk);
    chk("safe", {16'h1234, 1'h1}, {converter_code, narrow_span});
    // 4 mA plus 0x1234 of 16 mA in the narrow span
    chk("loop_ua", 32'h1411, loop_ua);
    ctrl = 4'h9;
    repeat (2) @(negedge clk);
    chk("span", {last, 1'h1}, {converter_code, narrow_span});
    {main_supply_ok, core_supply_ok} = 2'h1;
    repeat (2) @(negedge clk);
    chk("alarm", {16'h1234, 2'h1}, {converter_code, narrow_span, supply_alarm});
    {main_supply_ok, core_supply_ok} = 2'h3;
    repeat (2) @(negedge clk);
    chk("recover", {last, 1'h1}, {converter_code, narrow_span});
    chk("flags", 2'h0, {in_safe_state, supply_alarm});
    summarize();
  end
endmodule
